// ---- rtl/aclcs_pkg.sv ----
package aclcs_pkg;

  // register bus geometry
  localparam int unsigned ACLCS_ADDR_W = 16;
  localparam int unsigned ACLCS_DATA_W = 32;
  localparam int unsigned ACLCS_CTL_W  = 18;

  // register byte addresses
  localparam logic [ACLCS_ADDR_W-1:0] ACLCS_OFS_SET = 16'hF700;
  localparam logic [ACLCS_ADDR_W-1:0] ACLCS_OFS_CLR = 16'hF704;
  localparam logic [ACLCS_ADDR_W-1:0] ACLCS_OFS_STS = 16'hF708;

  // control field positions
  localparam int unsigned ACLCS_B_LINK_RELEASE  = 0;
  localparam int unsigned ACLCS_B_SLEEP_FORCE   = 1;
  localparam int unsigned ACLCS_B_RESUME_DETECT = 2;
  localparam int unsigned ACLCS_B_WARM_RESET    = 3;
  localparam int unsigned ACLCS_B_MIC_SELECT    = 4;
  localparam int unsigned ACLCS_B_READY_CLEAR   = 5;
  localparam int unsigned ACLCS_B_HALT_LSB      = 16;

  // storage bits that software may set or clear; everything else reads zero
  localparam logic [ACLCS_CTL_W-1:0] ACLCS_CTL_MASK  = 18'h3DF1F;
  localparam logic [ACLCS_CTL_W-1:0] ACLCS_CTL_RESET = 18'h00000;

  // dma channels: pcm tx, surround tx, center tx, bass tx, audio rx, modem tx, modem rx
  localparam int unsigned ACLCS_CH_N   = 7;
  localparam int unsigned ACLCS_HALT_N = 2;
  localparam int unsigned ACLCS_CH_BIT [0:ACLCS_CH_N-1] = '{8, 9, 10, 11, 12, 14, 15};

  // pin synchroniser depth
  localparam int unsigned ACLCS_SYNC_STAGES = 2;

  // status register layout
  localparam int unsigned ACLCS_S_READY_LSB = 0;
  localparam int unsigned ACLCS_S_HALT_LSB  = 2;
  localparam int unsigned ACLCS_CODEC_N     = 2;

endpackage

// ---- rtl/aclcs_sync2.sv ----
`timescale 1ns/100ps
module aclcs_sync2 #(
  parameter int unsigned W = 2
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ---- rtl/aclcs_halt.sv ----
`timescale 1ns/100ps
module aclcs_halt (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // control
  input  wire logic halt_en,
  input  wire logic underrun,
  // state
  output logic      halted
);

  // once halted the channel stays stopped until the halt enable is cleared
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      halted <= 1'b0;
    end else if (!halt_en) begin
      halted <= 1'b0;
    end else if (underrun) begin
      halted <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_halt_release: assert property (!halt_en |=> !halted)
    else $error("halt state survived a cleared halt enable");

endmodule

// ---- rtl/aclcs_ctrl.sv ----
`timescale 1ns/100ps
module aclcs_ctrl
  import aclcs_pkg::*;
(
  // clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                rstn,
  // register port
  input  wire logic [aclcs_pkg::ACLCS_ADDR_W-1:0]  addr,
  input  wire logic [aclcs_pkg::ACLCS_DATA_W-1:0]  wdata,
  input  wire logic                                wr,
  input  wire logic                                rd,
  output logic      [aclcs_pkg::ACLCS_DATA_W-1:0]  rdata,
  // dma channels
  input  wire logic [aclcs_pkg::ACLCS_CH_N-1:0]    dma_req_in,
  input  wire logic [aclcs_pkg::ACLCS_HALT_N-1:0]  underrun,
  output logic      [aclcs_pkg::ACLCS_CH_N-1:0]    dma_req,
  // codec readiness from the frame logic
  input  wire logic [aclcs_pkg::ACLCS_CODEC_N-1:0] codec_ready_evt,
  // frame logic link outputs
  input  wire logic                                sync_in,
  input  wire logic                                sdout_in,
  // link pins
  input  wire logic [aclcs_pkg::ACLCS_CODEC_N-1:0] sdin,
  output logic                                     link_sync,
  output logic                                     link_sdout,
  output logic                                     warm_reset,
  output logic                                     link_cold_reset_n,
  // receive path control and wake
  output logic                                     mic_source_select,
  output logic                                     power_event_irq
);
  import aclcs_pkg::*;

  logic [ACLCS_CTL_W-1:0]   ctl;
  logic [ACLCS_CODEC_N-1:0] codec_ready;
  logic [ACLCS_CODEC_N-1:0] sdin_sync;
  logic [ACLCS_HALT_N-1:0]  halted;
  logic [ACLCS_CH_N-1:0]    blocked;
  logic                     set_wr;
  logic                     clr_wr;
  logic                     ready_clear;
  logic [ACLCS_CTL_W-1:0]   wr_bits;

  assign set_wr      = wr && (addr == ACLCS_OFS_SET);
  assign clr_wr      = wr && (addr == ACLCS_OFS_CLR);
  assign wr_bits     = wdata[ACLCS_CTL_W-1:0] & ACLCS_CTL_MASK;
  assign ready_clear = set_wr && wdata[ACLCS_B_READY_CLEAR];

  // control storage: set register ors bits in, clear register takes them out
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctl <= ACLCS_CTL_RESET;
    end else if (set_wr) begin
      ctl <= ctl | wr_bits;
    end else if (clr_wr) begin
      ctl <= ctl & ~wr_bits;
    end
  end

  // codec ready flags; a ready event in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      codec_ready <= '0;
    end else begin
      codec_ready <= codec_ready_evt | (codec_ready & {ACLCS_CODEC_N{!ready_clear}});
    end
  end

  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (!rd) begin
      rdata <= '0;
    end else if (addr == ACLCS_OFS_SET) begin
      rdata <= {{(ACLCS_DATA_W-ACLCS_CTL_W){1'b0}}, ctl & ACLCS_CTL_MASK};
    end else if (addr == ACLCS_OFS_STS) begin
      rdata <= {{(ACLCS_DATA_W-ACLCS_S_HALT_LSB-ACLCS_HALT_N){1'b0}}, halted, codec_ready};
    end else begin
      rdata <= '0;
    end
  end

  // halt tracking for the two transmit channels that can stop on underrun
  genvar h;
  generate
    for (h = 0; h < ACLCS_HALT_N; h++) begin : g_halt
      aclcs_halt u_halt (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .halt_en  (ctl[ACLCS_B_HALT_LSB+h]),
        .underrun (underrun[h]),
        .halted   (halted[h])
      );
    end
  endgenerate

  // per-channel request gating
  genvar c;
  generate
    for (c = 0; c < ACLCS_CH_N; c++) begin : g_ch
      if (c < ACLCS_HALT_N) begin : g_hb
        assign blocked[c] = halted[c];
      end else begin : g_nb
        assign blocked[c] = 1'b0;
      end
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          dma_req[c] <= 1'b0;
        end else begin
          dma_req[c] <= dma_req_in[c] && ctl[ACLCS_CH_BIT[c]] && !blocked[c];
        end
      end
    end
  endgenerate

  // codec serial inputs come from pins
  aclcs_sync2 #(
    .W (ACLCS_CODEC_N)
  ) u_sdin_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in (sdin),
    .sync_out (sdin_sync)
  );

  // wake request follows the serial inputs while detection is enabled
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      power_event_irq <= 1'b0;
    end else begin
      power_event_irq <= ctl[ACLCS_B_RESUME_DETECT] && (|sdin_sync);
    end
  end

  // link pins; sleep forcing holds sync and sdout low over warm reset and frame data, while warm_reset still follows its bit
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      link_sync  <= 1'b0;
      link_sdout <= 1'b0;
      warm_reset <= 1'b0;
    end else begin
      warm_reset <= ctl[ACLCS_B_WARM_RESET];
      if (ctl[ACLCS_B_SLEEP_FORCE]) begin
        link_sync  <= 1'b0;
        link_sdout <= 1'b0;
      end else begin
        link_sync  <= sync_in || ctl[ACLCS_B_WARM_RESET];
        link_sdout <= sdout_in;
      end
    end
  end

  // cold reset stays asserted from reset until software releases the link
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      link_cold_reset_n <= 1'b0;
    end else begin
      link_cold_reset_n <= ctl[ACLCS_B_LINK_RELEASE];
    end
  end

  // receive source: 1 microphone slot, 0 pcm slots
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mic_source_select <= 1'b0;
    end else begin
      mic_source_select <= ctl[ACLCS_B_MIC_SELECT];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_set_write;
    set_wr;
  endsequence

  sequence s_halt_underrun(int unsigned ch);
    ctl[ACLCS_B_HALT_LSB+ch] && underrun[ch];
  endsequence

  sequence s_wake_held;
    (ctl[ACLCS_B_RESUME_DETECT] && (|sdin)) [*4];
  endsequence

  chk_set_takes_ones: assert property (s_set_write |=> ((ctl & $past(wr_bits)) == $past(wr_bits)))
    else $error("written ones not set in control");

  chk_zero_no_effect: assert property (s_set_write |=> ((ctl & $past(ctl)) == $past(ctl)))
    else $error("set write cleared a control bit");

  chk_clear_only_path: assert property ((|($past(ctl) & ~ctl)) |-> $past(clr_wr))
    else $error("control bit fell without a clear write");

  chk_reserved_zero: assert property (rd |=> ((rdata[ACLCS_CTL_W-1:0] & ~ACLCS_CTL_MASK) == '0 &&
                                               rdata[ACLCS_DATA_W-1:ACLCS_CTL_W] == '0))
    else $error("reserved read bits not zero");

  chk_halt_surround: assert property (s_halt_underrun(1) ##1 ctl[ACLCS_B_HALT_LSB+1] |=> !dma_req[1])
    else $error("surround request after halted underrun");

  chk_halt_pcm: assert property (s_halt_underrun(0) ##1 ctl[ACLCS_B_HALT_LSB] |=> !dma_req[0])
    else $error("pcm request after halted underrun");

  chk_ready_clear: assert property (ready_clear |=> ((codec_ready & ~$past(codec_ready_evt)) == '0))
    else $error("codec ready flags survived ready clear");

  chk_wake_irq: assert property (s_wake_held |-> power_event_irq)
    else $error("wake irq missing while serial input high");

  chk_sleep_pins: assert property (ctl[ACLCS_B_SLEEP_FORCE] |=> (!link_sync && !link_sdout))
    else $error("link pins not forced low in sleep");

  chk_cold_release: assert property (set_wr && wdata[ACLCS_B_LINK_RELEASE] |=> ##1 link_cold_reset_n)
    else $error("cold reset not released two cycles after write");

  chk_dma_enable: assert property (dma_req[6] |-> $past(ctl[ACLCS_CH_BIT[6]]))
    else $error("modem rx request while disabled");

  chk_warm_pin: assert property (ctl[ACLCS_B_WARM_RESET] && !ctl[ACLCS_B_SLEEP_FORCE] |=> warm_reset && link_sync)
    else $error("warm reset not driven on link");

  chk_mic_follow: assert property (s_set_write ##0 wdata[ACLCS_B_MIC_SELECT] |=> ##1 mic_source_select)
    else $error("mic select not applied");

  sequence s_clear_write;
    clr_wr;
  endsequence

  sequence s_read_req;
    rd;
  endsequence

  // register storage
  chk_set_keeps_rest: assert property (s_set_write |=> (((ctl ^ $past(ctl)) & ~$past(wr_bits)) == '0))
    else $error("set write changed an unwritten bit");

  chk_clear_takes_bits: assert property (s_clear_write |=> ((ctl & $past(wr_bits)) == '0))
    else $error("clear write left a written bit set");

  chk_clear_keeps_rest: assert property (s_clear_write |=> (((ctl ^ $past(ctl)) & ~$past(wr_bits)) == '0))
    else $error("clear write changed an unwritten bit");

  chk_idle_holds: assert property (!set_wr && !clr_wr |=> $stable(ctl))
    else $error("control changed without a register write");

  // read path
  chk_rdata_idle: assert property (!rd |=> (rdata == '0))
    else $error("read data not zero outside a read");

  chk_set_readback: assert property (s_read_req ##0 (addr == ACLCS_OFS_SET) |=>
                                     (rdata[ACLCS_CTL_W-1:0] == $past(ctl)))
    else $error("set register read does not match control");

  chk_status_readback: assert property (s_read_req ##0 (addr == ACLCS_OFS_STS) |=>
                                        (rdata[ACLCS_S_READY_LSB +: ACLCS_CODEC_N] == $past(codec_ready) &&
                                         rdata[ACLCS_S_HALT_LSB +: ACLCS_HALT_N] == $past(halted)))
    else $error("status read does not match ready and halt state");

  chk_clear_reads_zero: assert property (s_read_req ##0 (addr == ACLCS_OFS_CLR) |=> (rdata == '0))
    else $error("clear register read not zero");

  chk_ready_write_only: assert property (s_read_req |=> !rdata[ACLCS_B_READY_CLEAR])
    else $error("ready clear bit read back as one");

  // codec ready flags
  chk_ready_event: assert property ((|codec_ready_evt) |=>
                                    ((codec_ready & $past(codec_ready_evt)) == $past(codec_ready_evt)))
    else $error("codec ready event not recorded");

  chk_ready_hold: assert property (!ready_clear && !(|codec_ready_evt) |=> $stable(codec_ready))
    else $error("codec ready flags changed without cause");

  // link pin and mic select outputs
  chk_warm_follow: assert property (ctl[ACLCS_B_WARM_RESET] |=> warm_reset)
    else $error("warm reset output not asserted");

  chk_warm_low: assert property (!ctl[ACLCS_B_WARM_RESET] |=> !warm_reset)
    else $error("warm reset output asserted while bit clear");

  chk_cold_hold: assert property (!ctl[ACLCS_B_LINK_RELEASE] |=> !link_cold_reset_n)
    else $error("cold reset released while link bit clear");

  chk_cold_follow: assert property (ctl[ACLCS_B_LINK_RELEASE] |=> link_cold_reset_n)
    else $error("cold reset held while link bit set");

  chk_mic_low: assert property (!ctl[ACLCS_B_MIC_SELECT] |=> !mic_source_select)
    else $error("mic slot selected while bit clear");

  chk_sdout_pass: assert property (!ctl[ACLCS_B_SLEEP_FORCE] |=> (link_sdout == $past(sdout_in)))
    else $error("serial output not passed through when awake");

  chk_sync_pass: assert property (!ctl[ACLCS_B_SLEEP_FORCE] |=>
                                  (link_sync == ($past(sync_in) || $past(ctl[ACLCS_B_WARM_RESET]))))
    else $error("sync output wrong when awake");

  // wake request
  chk_wake_masked: assert property (!ctl[ACLCS_B_RESUME_DETECT] |=> !power_event_irq)
    else $error("wake irq while detection disabled");

  chk_wake_quiet: assert property ((!(|sdin)) [*4] |-> !power_event_irq)
    else $error("wake irq while serial inputs low");

  // request gating per channel
  chk_dma_pcm: assert property (dma_req[0] |-> $past(ctl[ACLCS_CH_BIT[0]]))
    else $error("pcm tx request while disabled");

  chk_dma_surround: assert property (dma_req[1] |-> $past(ctl[ACLCS_CH_BIT[1]]))
    else $error("surround tx request while disabled");

  chk_dma_center: assert property (dma_req[2] |-> $past(ctl[ACLCS_CH_BIT[2]]))
    else $error("center tx request while disabled");

  chk_dma_bass: assert property (dma_req[3] |-> $past(ctl[ACLCS_CH_BIT[3]]))
    else $error("bass tx request while disabled");

  chk_dma_audio_rx: assert property (dma_req[4] |-> $past(ctl[ACLCS_CH_BIT[4]]))
    else $error("audio rx request while disabled");

  chk_dma_modem_tx: assert property (dma_req[5] |-> $past(ctl[ACLCS_CH_BIT[5]]))
    else $error("modem tx request while disabled");

  chk_dma_source: assert property ((dma_req & ~$past(dma_req_in)) == '0)
    else $error("request issued without a raw request");

  chk_halted_pcm: assert property (halted[0] |=> !dma_req[0])
    else $error("pcm request while halted");

  chk_halted_surround: assert property (halted[1] |=> !dma_req[1])
    else $error("surround request while halted");

endmodule

// ---- bench/aclcs_codec_model.sv ----
`timescale 1ns/100ps
module aclcs_codec_model (
  // link from the controller
  input  wire logic       link_cold_reset_n,
  input  wire logic       link_sync,
  // wake command from the bench
  input  wire logic [1:0] wake_line,
  // serial inputs back to the controller
  output logic      [1:0] sdin
);
  // held in cold reset or framed, the codec keeps its lines low; wake edges land off the clock
  assign #30 sdin = (link_cold_reset_n && !link_sync) ? wake_line : 2'b00;
endmodule

// ---- bench/aclcs_ctrl_test.sv ----
`timescale 1ns/100ps
module aclcs_ctrl_test;
  import aclcs_pkg::*;
  logic                    sys_clk;
  logic                    rstn;
  logic                    wr;
  logic                    rd;
  logic                    sync_in;
  logic                    sdout_in;
  logic [ACLCS_ADDR_W-1:0] addr;
  logic [ACLCS_DATA_W-1:0] wdata;
  logic [ACLCS_DATA_W-1:0] rdata;
  logic [ACLCS_DATA_W-1:0] d;
  logic [ACLCS_CH_N-1:0]   dma_req_in;
  logic [ACLCS_CH_N-1:0]   dma_req;
  logic [1:0]              underrun;
  logic [1:0]              codec_ready_evt;
  logic [1:0]              sdin;
  logic [1:0]              wake_line;
  logic                    link_sync;
  logic                    link_sdout;
  logic                    warm_reset;
  logic                    link_cold_reset_n;
  logic                    mic_source_select;
  logic                    power_event_irq;
  int                      num_errors;
  int                      n_checks;

  aclcs_ctrl dut (.sys_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .dma_req_in, .underrun, .dma_req,
    .codec_ready_evt, .sync_in, .sdout_in, .sdin, .link_sync, .link_sdout, .warm_reset,
    .link_cold_reset_n, .mic_source_select, .power_event_irq);
  aclcs_codec_model codec (.link_cold_reset_n, .link_sync, .wake_line, .sdin);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wreg(input logic [15:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [15:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic [31:0] pins();
    return {26'h0, warm_reset, link_cold_reset_n, mic_source_select, link_sync, link_sdout, power_event_irq};
  endfunction

  task automatic t_bits();
    logic [31:0] acc;
    acc = 32'h0;
    for (int i = 0; i < 32; i++) begin
      wreg(ACLCS_OFS_SET, 32'h1 << i);
      acc |= (32'h1 << i) & 32'(ACLCS_CTL_MASK);
      rreg(ACLCS_OFS_SET, d);
      chk("set_reg", acc, d);
    end
    wreg(ACLCS_OFS_SET, 32'h0);
    wreg(16'h0010, 32'hFFFFFFFF);
    rreg(ACLCS_OFS_SET, d);
    chk("set_after_zero", acc, d);
    rreg(16'h0010, d);
    chk("unmapped", 32'h0, d);
    @(posedge sys_clk) sync_in <= 1'b1;
    settle(1);
    chk("pins_sleep", 32'h38, pins());
    wreg(ACLCS_OFS_CLR, 32'h2);
    settle(1);
    chk("pins_awake", 32'h3E, pins());
    wreg(ACLCS_OFS_CLR, 32'hFFFFFFFF);
    rreg(ACLCS_OFS_SET, d);
    chk("set_cleared", 32'h0, d);
    chk("pins_cleared", 32'h06, pins());
    @(posedge sys_clk) sync_in <= 1'b0;
  endtask

  task automatic t_dma();
    logic [ACLCS_CH_N-1:0] e;
    e = '0;
    for (int j = 0; j < ACLCS_CH_N; j++) begin
      wreg(ACLCS_OFS_SET, 32'h1 << ACLCS_CH_BIT[j]);
      settle(1);
      e[j] = 1'b1;
      chk("dma_req", 32'(e), 32'(dma_req));
    end
    @(posedge sys_clk) dma_req_in <= '0;
    settle(1);
    chk("dma_idle", 32'h0, 32'(dma_req));
    @(posedge sys_clk) dma_req_in <= '1;
    wreg(ACLCS_OFS_CLR, 32'h0000DF00);
    settle(1);
    chk("dma_off", 32'h0, 32'(dma_req));
  endtask

  task automatic t_halt(input int h);
    wreg(ACLCS_OFS_SET, (32'h1 << ACLCS_CH_BIT[h]) | (32'h1 << (16 + h)));
    settle(1);
    chk("req_before", 32'h1, 32'(dma_req[h]));
    @(posedge sys_clk) underrun <= 2'b01 << h;
    @(posedge sys_clk) underrun <= 2'b00;
    settle(2);
    chk("req_halted", 32'h0, 32'(dma_req[h]));
    rreg(ACLCS_OFS_STS, d);
    chk("halt_status", 32'h4 << h, d);
    wreg(ACLCS_OFS_CLR, 32'h1 << (16 + h));
    settle(2);
    chk("req_resumed", 32'h1, 32'(dma_req[h]));
    @(posedge sys_clk) underrun <= 2'b01 << h;
    @(posedge sys_clk) underrun <= 2'b00;
    settle(2);
    chk("req_no_halt", 32'h1, 32'(dma_req[h]));
    wreg(ACLCS_OFS_CLR, 32'h1 << ACLCS_CH_BIT[h]);
  endtask

  task automatic t_ready();
    @(posedge sys_clk) codec_ready_evt <= 2'b11;
    @(posedge sys_clk) codec_ready_evt <= 2'b00;
    rreg(ACLCS_OFS_STS, d);
    chk("ready_set", 32'h3, d);
    wreg(ACLCS_OFS_SET, 32'h20);
    rreg(ACLCS_OFS_STS, d);
    chk("ready_clr", 32'h0, d);
    rreg(ACLCS_OFS_SET, d);
    chk("ready_bit", 32'h1, d);
  endtask

  task automatic t_wake();
    wreg(ACLCS_OFS_SET, 32'h4);
    @(posedge sys_clk) wake_line <= 2'b10;
    settle(2);
    chk("irq_early", 32'h0, 32'(power_event_irq));
    settle(1);
    chk("irq_on", 32'h1, 32'(power_event_irq));
    @(posedge sys_clk) wake_line <= 2'b00;
    settle(4);
    chk("irq_off", 32'h0, 32'(power_event_irq));
    wreg(ACLCS_OFS_CLR, 32'h4);
    @(posedge sys_clk) wake_line <= 2'b01;
    settle(4);
    chk("irq_masked", 32'h0, 32'(power_event_irq));
    @(posedge sys_clk) wake_line <= 2'b00;
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    {rstn, wr, rd, sync_in, addr, wdata, underrun, codec_ready_evt, wake_line} = '0;
    sdout_in = 1'b1;
    dma_req_in = '1;
    num_errors = 0;
    n_checks = 0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    rreg(ACLCS_OFS_SET, d);
    chk("reset_reg", 32'h0, d);
    chk("reset_pins", 32'h2, pins());
    t_bits();
    t_dma();
    for (int h = 0; h < ACLCS_HALT_N; h++) t_halt(h);
    wreg(ACLCS_OFS_SET, 32'h1);
    t_ready();
    t_wake();
    final_report();
  end

  initial begin
    #2000000;
    num_errors++;
    final_report();
  end
endmodule
